// File: sdr_ctrl_model.sv
// memory controller model: drives commands, mask and write data
`timescale 1ns/1ns
module sdr_ctrl_model (
    input wire logic sys_clk, // clock
    output logic cke, // clock enable
    output logic cs_n, // select
    output logic ras_n, // row strobe
    output logic cas_n, // column strobe
    output logic we_n, // write strobe
    output logic ba, // bank
    output logic [sdr_pkg::ADDR_W-1:0] addr, // address
    output logic [1:0] dqm, // byte mask
    output logic [sdr_pkg::DATA_W-1:0] dq_in // write data
);
    import sdr_pkg::*;
    logic dq_drv = 1'b0;
    initial begin
        dq_in = 16'h5A5A;
        mask(2'b00);
        power(1'b1, CMD_NOP);
    end
    // released data lines toggle so stale write data never looks valid
    always @(posedge sys_clk) begin
        if (!dq_drv) dq_in <= ~dq_in;
    end
    task automatic put(input sdr_cmd_e c, input logic b, input logic [ADDR_W-1:0] a);
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
    endtask : put
    function automatic logic [ADDR_W-1:0] mode_word(input logic [2:0] bl, input logic il,
                                                    input logic wm, input logic [2:0] cl = 3'h2);
        return {1'b0, wm, 2'b00, cl, il, bl};
    endfunction : mode_word
    task automatic data(input logic [DATA_W-1:0] d, input logic [1:0] m);
        dq_drv = 1'b1;
        dq_in = d;
        dqm = m;
    endtask : data
    // mask also serves as read output disable ahead of a write
    task automatic mask(input logic [1:0] m);
        dq_drv = 1'b0;
        dqm = m;
    endtask : mask
    task automatic power(input logic en, input sdr_cmd_e c);
        cke = en;
        put(c, 1'b0, '0);
    endtask : power
endmodule : sdr_ctrl_model

// File: sdr_device.sv
// command-level model of a two-bank 16-bit synchronous dram
// Summary of operation
// - write-mode bit set makes every write a single word
// - one bank may be activated and precharged while the other bursts
// - new read or write in open row interrupts running burst
// - auto-precharge closes the bank by itself after the burst
// - internal precharge waits until minimum row open time passed
// - burst terminate ends the burst and leaves the row open
// - precharge to the bursting bank ends burst and closes row
// - masked write words or bytes are not stored
// - masked read cycles leave data outputs disabled
// - auto refresh needs banks closed, then an idle interval
// - self refresh with banks closed, clock enable low, then recovery
// - clock enable sampled low enters power-down, data outputs and drive frozen as they were
`timescale 1ns/1ns
module sdr_device (
    input wire logic sys_clk, // clock, 100 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select, active low
    input wire logic ras_n, // row strobe, active low
    input wire logic cas_n, // column strobe, active low
    input wire logic we_n, // write strobe, active low
    input wire logic ba, // bank select
    input wire logic [sdr_pkg::ADDR_W-1:0] addr, // row, column or mode value
    input wire logic [1:0] dqm, // byte mask, bit 1 upper byte
    input wire logic [sdr_pkg::DATA_W-1:0] dq_in, // data pin input
    output logic [sdr_pkg::DATA_W-1:0] dq_out, // data pin output
    output logic [1:0] dq_oe, // data pin drive per byte
    output logic [1:0] bank_open, // row open per bank
    output logic [1:0] internal_precharge_start, // auto-precharge begins, pulse
    output logic power_down, // in power-down
    output logic self_refresh // in self refresh
);
    import sdr_pkg::*;

    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] code);
        unique case (code)
            BL_2: burst_mask = 8'h01;
            BL_4: burst_mask = 8'h03;
            BL_8: burst_mask = 8'h07;
            BL_FULL: burst_mask = 8'hFF;
            default: burst_mask = 8'h00;
        endcase
    endfunction : burst_mask

    function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] start,
                                                input logic [CNT_W-1:0] cnt,
                                                input logic [COL_W-1:0] msk,
                                                input logic il);
        logic [COL_W-1:0] off;
        off = il ? (start ^ cnt[COL_W-1:0]) : COL_W'(start + cnt[COL_W-1:0]);
        col_at = (start & ~msk) | (off & msk);
    endfunction : col_at

    sdr_cmd_e cmd;
    sdr_pwr_e pwr_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [3:0] ref_cnt_ff;
    logic [3:0] srx_cnt_ff;
    logic bst_act_ff, bst_wr_ff, bst_bank_ff, bst_ap_ff, bst_il_ff;
    logic [COL_W-1:0] bst_start_ff, bst_mask_ff;
    logic [CNT_W-1:0] bst_cnt_ff, bst_len_ff;
    logic [1:0] open_ff, ap_pend_ff, pchg_ff;
    logic [ADDR_W-1:0] row_ff [2];
    logic [3:0] ras_cnt_ff [2];
    logic [1:0] rd_v_ff;
    logic [DATA_W-1:0] rd_d_ff [2];
    logic [DATA_W-1:0] dq_out_ff;
    logic [1:0] dq_oe_ff;
    logic power_down_ff, self_refresh_ff;

    logic run, live, all_closed, step, last, is_rw, is_wr, stop_bst, wr_en;
    logic [2:0] bl_code;
    logic [CNT_W-1:0] new_len;
    logic [COL_W-1:0] new_mask, eng_col;
    logic [1:0] ap_req;
    logic [STORE_AW-1:0] wr_idx, rd_idx;
    logic [DATA_W-1:0] rd_data;

    assign cmd = sdr_cmd_e'(cs_n ? 3'h7 : {ras_n, cas_n, we_n});
    // the edge that wakes the device is not a command edge
    assign run = cke && (pwr_ff == PWR_RUN);
    assign live = run && (ref_cnt_ff == 4'h0) && (srx_cnt_ff == 4'h0);
    assign all_closed = (open_ff == 2'b00);
    assign step = run && bst_act_ff;
    assign last = (CNT_W'(bst_cnt_ff + 9'h001) >= bst_len_ff);
    assign is_rw = live && ((cmd == CMD_RD) || (cmd == CMD_WR)) && open_ff[ba];
    assign is_wr = (cmd == CMD_WR);
    assign stop_bst = live && ((cmd == CMD_BST)
        || ((cmd == CMD_PRE) && (addr[AP_BIT] || (ba == bst_bank_ff))));

    assign bl_code = mode_ff[MR_BL_LSB +: 3];
    assign new_mask = burst_mask(bl_code);
    always_comb begin
        if (is_wr && mode_ff[MR_WMODE_BIT]) begin
            new_len = 9'h001;
        end else if (bl_code == BL_FULL) begin
            new_len = PAGE_WORDS;
        end else begin
            new_len = CNT_W'({1'b0, new_mask}) + 9'h001;
        end
    end

    assign eng_col = col_at(bst_start_ff, bst_cnt_ff, bst_mask_ff, bst_il_ff);
    assign rd_idx = {bst_bank_ff, row_ff[bst_bank_ff][ROW_KEEP-1:0], eng_col};
    assign wr_en = (is_rw && is_wr) || (step && bst_wr_ff && !is_rw && !stop_bst);
    assign wr_idx = (is_rw && is_wr) ? {ba, row_ff[ba][ROW_KEEP-1:0], addr[COL_W-1:0]}
                                     : rd_idx;

    // burst end with auto-precharge, or a one-word write carrying it
    always_comb begin
        ap_req = 2'b00;
        if (step && last && bst_ap_ff && !is_rw && !stop_bst) begin
            ap_req[bst_bank_ff] = 1'b1;
        end
        if (is_rw && is_wr && addr[AP_BIT] && (new_len == 9'h001)) begin
            ap_req[ba] = 1'b1;
        end
    end

    sdr_store u_store (
        .sys_clk(sys_clk),
        .wr_en(wr_en),
        .wr_be(~dqm),
        .wr_idx(wr_idx),
        .wr_data(dq_in),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // power state: clock enable low freezes everything else
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_ff <= PWR_RUN;
            power_down_ff <= 1'b0;
            self_refresh_ff <= 1'b0;
        end else begin
            unique case (pwr_ff)
                PWR_RUN: begin
                    if (!cke) begin
                        // the entry edge has clock enable low, so live cannot qualify it
                        if (cmd == CMD_REF && all_closed && !bst_act_ff
                                && ref_cnt_ff == 4'h0 && srx_cnt_ff == 4'h0) begin
                            pwr_ff <= PWR_SELF;
                            self_refresh_ff <= 1'b1;
                        end else begin
                            pwr_ff <= PWR_DOWN;
                            power_down_ff <= 1'b1;
                        end
                    end
                end
                PWR_DOWN: begin
                    if (cke) begin
                        pwr_ff <= PWR_RUN;
                        power_down_ff <= 1'b0;
                    end
                end
                PWR_SELF: begin
                    if (cke) begin
                        pwr_ff <= PWR_RUN;
                        self_refresh_ff <= 1'b0;
                    end
                end
                default: begin
                    pwr_ff <= PWR_RUN;
                    power_down_ff <= 1'b0;
                    self_refresh_ff <= 1'b0;
                end
            endcase
        end
    end

    // refresh busy and self refresh recovery counters
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_ff <= 4'h0;
            srx_cnt_ff <= 4'h0;
        end else if (pwr_ff == PWR_SELF && cke) begin
            srx_cnt_ff <= SRX_CYC - 4'h1;
        end else if (run) begin
            if (live && cmd == CMD_REF && all_closed && !bst_act_ff) begin
                ref_cnt_ff <= RC_CYC - 4'h1;
            end else if (ref_cnt_ff != 4'h0) begin
                ref_cnt_ff <= ref_cnt_ff - 4'h1;
            end
            if (srx_cnt_ff != 4'h0) begin
                srx_cnt_ff <= srx_cnt_ff - 4'h1;
            end
        end
    end

    // mode register, loaded only with both banks closed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= MR_RESET;
        end else if (live && cmd == CMD_MRS && all_closed && !bst_act_ff) begin
            mode_ff <= addr[MODE_W-1:0];
        end
    end

    // burst engine: one running burst, restarted by each read or write to an open bank
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bst_act_ff <= 1'b0;
            bst_wr_ff <= 1'b0;
            bst_bank_ff <= 1'b0;
            bst_ap_ff <= 1'b0;
            bst_il_ff <= 1'b0;
            bst_start_ff <= 8'h00;
            bst_mask_ff <= 8'h00;
            bst_cnt_ff <= 9'h000;
            bst_len_ff <= 9'h000;
        end else if (is_rw) begin
            bst_wr_ff <= is_wr;
            bst_bank_ff <= ba;
            bst_ap_ff <= addr[AP_BIT];
            bst_il_ff <= mode_ff[MR_ORDER_BIT] && (bl_code != BL_FULL);
            bst_start_ff <= addr[COL_W-1:0];
            bst_mask_ff <= new_mask;
            bst_len_ff <= new_len;
            bst_cnt_ff <= is_wr ? 9'h001 : 9'h000;
            bst_act_ff <= !(is_wr && new_len == 9'h001);
        end else if (stop_bst) begin
            bst_act_ff <= 1'b0;
        end else if (step) begin
            bst_cnt_ff <= CNT_W'(bst_cnt_ff + 9'h001);
            if (last) begin
                bst_act_ff <= 1'b0;
            end
        end
    end

    // per-bank row state and auto-precharge timing
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_bank
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    open_ff[b] <= 1'b0;
                    ap_pend_ff[b] <= 1'b0;
                    pchg_ff[b] <= 1'b0;
                    row_ff[b] <= 11'h000;
                    ras_cnt_ff[b] <= 4'h0;
                end else if (run) begin
                    pchg_ff[b] <= 1'b0;
                    if (ras_cnt_ff[b] != 4'h0) begin
                        ras_cnt_ff[b] <= ras_cnt_ff[b] - 4'h1;
                    end
                    if (live && cmd == CMD_ACT && ba == 1'(b) && !open_ff[b]) begin
                        open_ff[b] <= 1'b1;
                        row_ff[b] <= addr;
                        ras_cnt_ff[b] <= RAS_MIN_CYC - 4'h1;
                    end else if (live && cmd == CMD_PRE && (addr[AP_BIT] || ba == 1'(b))) begin
                        open_ff[b] <= 1'b0;
                        ap_pend_ff[b] <= 1'b0;
                    end else if (ap_req[b] || ap_pend_ff[b]) begin
                        if (ras_cnt_ff[b] == 4'h0) begin
                            open_ff[b] <= 1'b0;
                            ap_pend_ff[b] <= 1'b0;
                            pchg_ff[b] <= 1'b1;
                        end else begin
                            ap_pend_ff[b] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // read data pipe, tapped by the programmed latency
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_v_ff <= 2'b00;
            rd_d_ff[0] <= 16'h0000;
            rd_d_ff[1] <= 16'h0000;
            dq_out_ff <= 16'h0000;
            dq_oe_ff <= 2'b00;
        end else if (run) begin
            rd_v_ff <= {rd_v_ff[0], step && !bst_wr_ff};
            rd_d_ff[0] <= rd_data;
            rd_d_ff[1] <= rd_d_ff[0];
            if (mode_ff[MR_CL_LSB +: 3] >= CL_THREE) begin
                dq_out_ff <= rd_d_ff[1];
                dq_oe_ff <= {2{rd_v_ff[1]}} & ~dqm;
            end else begin
                dq_out_ff <= rd_d_ff[0];
                dq_oe_ff <= {2{rd_v_ff[0]}} & ~dqm;
            end
        end
    end

    assign dq_out = dq_out_ff;
    assign dq_oe = dq_oe_ff;
    assign bank_open = open_ff;
    assign internal_precharge_start = pchg_ff;
    assign power_down = power_down_ff;
    assign self_refresh = self_refresh_ff;
endmodule : sdr_device

// File: sdr_device_sva.sv
// assertions on the ports of the sdram device model
`timescale 1ns/1ns
module sdr_device_sva (
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic cke, // clock enable
    input wire logic cs_n, // select, active low
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write strobe
    input wire logic ba, // bank
    input wire logic [sdr_pkg::ADDR_W-1:0] addr, // address
    input wire logic [1:0] dqm, // byte mask
    input wire logic [1:0] dq_oe, // data drive
    input wire logic [1:0] bank_open, // open rows
    input wire logic [1:0] internal_precharge_start, // auto-precharge pulse
    input wire logic power_down, // power-down state
    input wire logic self_refresh // self refresh state
);
    import sdr_pkg::*;
    logic run;
    logic [2:0] cmd;
    logic [3:0] open_cnt_ff;
    assign run = cke && !power_down && !self_refresh && !cs_n;
    assign cmd = {ras_n, cas_n, we_n};
    // cycles since bank 0 opened, saturating
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) open_cnt_ff <= 4'h0;
        else if (!bank_open[0]) open_cnt_ff <= 4'h0;
        else if (open_cnt_ff != 4'hF) open_cnt_ff <= open_cnt_ff + 4'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_ap_close: assert property (internal_precharge_start != 2'b00 |->
        (internal_precharge_start & (bank_open | ~$past(bank_open))) == 2'b00) else $error("pulse without close");
    chk_ras_min: assert property (internal_precharge_start[0] |-> open_cnt_ff >= RAS_MIN_CYC)
        else $error("auto-precharge too early");
    chk_pd_entry: assert property ($rose(power_down) |-> !$past(cke))
        else $error("power-down without clock enable low");
    chk_pd_exit: assert property (power_down && cke |-> ##[1:2] !power_down)
        else $error("power-down not left");
    chk_sr_entry: assert property ($rose(self_refresh) |-> !$past(cke) && $past(bank_open) == 2'b00)
        else $error("self refresh entered wrongly");
    chk_sr_hold: assert property (self_refresh && !cke |=> self_refresh)
        else $error("self refresh left with clock enable low");
    chk_oe_mask: assert property (dq_oe != 2'b00 |-> (dq_oe & $past(dqm)) == 2'b00)
        else $error("masked byte driven");
    chk_bst_row: assert property (run && cmd == CMD_BST |=> bank_open == $past(bank_open))
        else $error("burst stop changed open rows");
    chk_pre_close: assert property (run && cmd == CMD_PRE |=>
        ($past(addr[10]) ? bank_open == 2'b00 : !bank_open[$past(ba)])) else $error("row not closed");
    cover property (internal_precharge_start[0]);
    cover property ($rose(power_down));
    cover property ($rose(self_refresh));
endmodule : sdr_device_sva

bind sdr_device sdr_device_sva sdr_device_sva_inst (.sys_clk, .rstn, .cke, .cs_n, .ras_n,
    .cas_n, .we_n, .ba, .addr, .dqm, .dq_oe, .bank_open, .internal_precharge_start,
    .power_down, .self_refresh);

// File: sdr_pkg.sv
// constants, field layouts and command codes shared by the sdram device model
package sdr_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RAS_MIN_NS = 42;
    localparam int T_RC_NS = 65;
    localparam int T_SRX_NS = 75;
    // min_row_open_time, refresh busy and self_refresh_exit_delay as cycle counts (round up)
    localparam logic [3:0] RAS_MIN_CYC = 4'((T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RC_CYC = 4'((T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] SRX_CYC = 4'((T_SRX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    localparam int COL_W = 8;
    localparam int CNT_W = 9;
    localparam int MODE_W = 10;
    localparam int ROW_KEEP = 2;
    localparam int STORE_AW = 1 + ROW_KEEP + COL_W;
    localparam int STORE_DEPTH = 1 << STORE_AW;

    // burst_and_latency_setup field positions and reset value
    localparam int MR_BL_LSB = 0;
    localparam int MR_ORDER_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_WMODE_BIT = 9;
    localparam int AP_BIT = 10;
    localparam logic [MODE_W-1:0] MR_RESET = 10'h020;
    localparam logic [2:0] CL_THREE = 3'h3;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h6;
    localparam logic [CNT_W-1:0] PAGE_WORDS = 9'h100;

    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR = 3'b100,
        CMD_RD = 3'b101,
        CMD_BST = 3'b110,
        CMD_NOP = 3'b111
    } sdr_cmd_e;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_SELF = 2'b10
    } sdr_pwr_e;
endpackage : sdr_pkg

// File: sdr_store.sv
// byte-lane flip-flop storage array for the sdram device model
`timescale 1ns/1ns
module sdr_store (
    input wire logic sys_clk, // clock
    input wire logic wr_en, // write this cycle
    input wire logic [1:0] wr_be, // byte lanes to store
    input wire logic [sdr_pkg::STORE_AW-1:0] wr_idx, // write word index
    input wire logic [sdr_pkg::DATA_W-1:0] wr_data, // write word
    input wire logic [sdr_pkg::STORE_AW-1:0] rd_idx, // read word index
    output logic [sdr_pkg::DATA_W-1:0] rd_data // read word, combinational
);
    import sdr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            logic [7:0] lane_ff [STORE_DEPTH];
            always_ff @(posedge sys_clk) begin
                if (wr_en && wr_be[g]) begin
                    lane_ff[wr_idx] <= wr_data[g*8 +: 8];
                end
            end
            assign rd_data[g*8 +: 8] = lane_ff[rd_idx];
        end
    endgenerate
endmodule : sdr_store

// File: tb_top.sv
// testbench: bursts, masks, precharge and power states of the sdram device model
`timescale 1ns/1ns
module tb_top;
    import sdr_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, ba, power_down, self_refresh;
    logic [ADDR_W-1:0] addr;
    logic [1:0] dqm, dq_oe, bank_open, ips;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [DATA_W-1:0] shadow [0:511];
    logic [2:0] codes [5] = '{BL_1, BL_2, BL_4, BL_8, BL_FULL};
    sdr_cmd_e stops [2] = '{CMD_BST, CMD_PRE};
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int ap_seen = 0;
    int n;
    int lat = 2;
    always #5 sys_clk = ~sys_clk;
    sdr_device sdr_device_inst (.sys_clk, .rstn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .dqm, .dq_in, .dq_out, .dq_oe, .bank_open, .internal_precharge_start(ips),
        .power_down, .self_refresh);
    sdr_ctrl_model sdr_ctrl_model_inst (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .dqm, .dq_in);
    always @(posedge sys_clk) begin
        cyc++;
        if (ips[0] === 1'b1) ap_seen++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] col_at(input logic [7:0] s, input int i, input int n,
                                          input logic il);
        logic [7:0] m;
        m = 8'(n - 1);
        if (il) return (s & ~m) | ((s ^ 8'(i)) & m);
        return (s & ~m) | (8'(s + 8'(i)) & m);
    endfunction : col_at
    task automatic op(input sdr_cmd_e c, input logic b, input logic [ADDR_W-1:0] a, input int gap);
        @(negedge sys_clk);
        sdr_ctrl_model_inst.put(c, b, a);
        repeat (gap) begin
            @(negedge sys_clk);
            sdr_ctrl_model_inst.put(CMD_NOP, 1'b0, '0);
        end
    endtask : op
    task automatic wr(input logic b, input logic [7:0] s, input int n, input int nw, input int mi,
                      input logic il, input logic [7:0] t);
        logic [7:0] c;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            c = col_at(s, i, n, il);
            sdr_ctrl_model_inst.put(i == 0 ? CMD_WR : CMD_NOP, b, {3'h0, s});
            sdr_ctrl_model_inst.data({t, c}, i == mi ? 2'b11 : 2'b00);
            if (i < nw && i != mi) shadow[{b, c}] = {t, c};
        end
        @(negedge sys_clk);
        sdr_ctrl_model_inst.put(CMD_NOP, 1'b0, '0);
        sdr_ctrl_model_inst.mask(2'b00);
    endtask : wr
    task automatic rd(input logic b, input logic [7:0] s, input int n, input int mi, input logic il,
                      input logic ap);
        for (int m = 0; m <= n + lat + 1; m++) begin
            @(negedge sys_clk);
            if (m > lat && m <= n + lat) begin
                chk({14'h0, dq_oe}, m - lat - 1 == mi ? 16'h0 : 16'h3);
                if (m - lat - 1 != mi) chk(dq_out, shadow[{b, col_at(s, m - lat - 1, n, il)}]);
            end
            if (m == n + lat + 1) chk({14'h0, dq_oe}, 16'h0);
            sdr_ctrl_model_inst.put(m == 0 ? CMD_RD : CMD_NOP, b, {ap, 2'h0, s});
            sdr_ctrl_model_inst.mask(mi >= 0 && m - lat == mi ? 2'b11 : 2'b00);
        end
    endtask : rd
    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        foreach (codes[k]) begin
            n = codes[k] == BL_FULL ? 256 : 1 << codes[k];
            op(CMD_PRE, 1'b0, 11'h400, 1);
            op(CMD_MRS, 1'b0, sdr_ctrl_model_inst.mode_word(codes[k], 1'b0, 1'b0), 2);
            op(CMD_ACT, 1'b0, 11'h0, 1);
            wr(1'b0, 8'h5, n, n, -1, 1'b0, 8'(k));
            rd(1'b0, col_at(8'h5, 1, n, 1'b0), n, -1, 1'b0, 1'b0);
        end
        op(CMD_PRE, 1'b0, 11'h400, 1);
        op(CMD_MRS, 1'b0, sdr_ctrl_model_inst.mode_word(BL_8, 1'b1, 1'b0), 2);
        op(CMD_ACT, 1'b0, 11'h0, 1);
        wr(1'b0, 8'h9, 8, 8, 3, 1'b1, 8'hB);
        rd(1'b0, 8'h9, 8, 2, 1'b1, 1'b0);
        op(CMD_PRE, 1'b0, 11'h400, 1);
        op(CMD_MRS, 1'b0,
           sdr_ctrl_model_inst.mode_word(BL_4, 1'b0, 1'b0, CL_THREE), 2);
        op(CMD_ACT, 1'b0, 11'h0, 1);
        lat = 3;
        op(CMD_RD, 1'b0, 11'h0, 0);
        rd(1'b0, 8'h4, 4, 1, 1'b0, 1'b0);
        lat = 2;
        op(CMD_PRE, 1'b0, 11'h400, 1);
        op(CMD_MRS, 1'b0, sdr_ctrl_model_inst.mode_word(BL_8, 1'b0, 1'b1), 2);
        op(CMD_ACT, 1'b0, 11'h0, 1);
        wr(1'b0, 8'h20, 8, 1, -1, 1'b0, 8'hC);
        rd(1'b0, 8'h20, 8, -1, 1'b0, 1'b0);
        rd(1'b0, 8'h0, 8, -1, 1'b0, 1'b1);
        chk({15'h0, bank_open[0]}, 16'h0);
        chk(16'(ap_seen), 16'h1);
        op(CMD_ACT, 1'b0, 11'h0, 1);
        foreach (stops[k]) begin
            op(CMD_RD, 1'b0, 11'h0, 0);
            op(stops[k], 1'b0, 11'h0, 7);
            chk({14'h0, dq_oe}, 16'h0);
            chk({15'h0, bank_open[0]}, 16'(k == 0));
        end
        op(CMD_ACT, 1'b0, 11'h0, 0);
        op(CMD_WR, 1'b0, 11'h400, 2);
        chk({15'h0, bank_open[0]}, 16'h1);
        op(CMD_NOP, 1'b0, 11'h0, 3);
        chk({15'h0, bank_open[0]}, 16'h0);
        chk(16'(ap_seen), 16'h2);
        op(CMD_REF, 1'b0, 11'h0, RC_CYC);
        @(negedge sys_clk);
        sdr_ctrl_model_inst.power(1'b0, CMD_NOP);
        repeat (3) @(negedge sys_clk);
        chk({15'h0, power_down}, 16'h1);
        sdr_ctrl_model_inst.power(1'b1, CMD_NOP);
        op(CMD_NOP, 1'b0, 11'h0, 2);
        chk({15'h0, power_down}, 16'h0);
        sdr_ctrl_model_inst.power(1'b0, CMD_REF);
        repeat (3) @(negedge sys_clk);
        chk({15'h0, self_refresh}, 16'h1);
        sdr_ctrl_model_inst.power(1'b1, CMD_NOP);
        op(CMD_NOP, 1'b0, 11'h0, SRX_CYC);
        chk({15'h0, self_refresh}, 16'h0);
        op(CMD_ACT, 1'b1, 11'h0, 0);
        op(CMD_ACT, 1'b0, 11'h0, 1);
        chk({14'h0, bank_open}, 16'h3);
        final_report();
    end
endmodule : tb_top
